/* hdl/mia_defines.vh */
// Register offsets, field positions and reset values of the MAC interrupt aggregator.
// Assumes inclusion by bare name from the design files under hdl/.
`ifndef MIA_DEFINES_VH
`define MIA_DEFINES_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define MIA_ADDR_W          8
`define MIA_OFS_VECTOR      8'h00
`define MIA_OFS_USER_RAW    8'h04
`define MIA_OFS_USER_MASKED 8'h08
`define MIA_OFS_USER_EN_SET 8'h0C
`define MIA_OFS_USER_EN_CLR 8'h10
`define MIA_OFS_TX_EN_SET   8'h14
`define MIA_OFS_TX_EN_CLR   8'h18
`define MIA_OFS_RX_EN_SET   8'h1C
`define MIA_OFS_RX_EN_CLR   8'h20
`define MIA_OFS_MAC_EN_SET  8'h24
`define MIA_OFS_MAC_EN_CLR  8'h28
`define MIA_OFS_GATE        8'h2C
`define MIA_OFS_EVT_STAT    8'h30
`define MIA_OFS_EVT_MASK    8'h34

// ****************************************************************
// Field layouts
// ****************************************************************
`define MIA_VEC_RX_LSB      0
`define MIA_VEC_THR_LSB     8
`define MIA_VEC_TX_LSB      16
`define MIA_VEC_USER        24
`define MIA_VEC_LINK        25
`define MIA_VEC_HOST        26
`define MIA_VEC_STAT        27
`define MIA_RX_THR_EN_LSB   8
`define MIA_MAC_EN_STAT     0
`define MIA_MAC_EN_HOST     1
`define MIA_EVT_RX_LSB      8
`define MIA_EVT_USER_LSB    16
`define MIA_EVT_HOST        18
`define MIA_EVT_W           19
`define MIA_GATE_W          12
`define MIA_CORES           3
`define MIA_CHANS           8
`define MIA_CNT_W           16
`define MIA_SYS_EVENT_BASE  5

// ****************************************************************
// Reset values
// ****************************************************************
`define MIA_ZERO32          32'h0000_0000
`define MIA_GATE_RST        12'h000
`endif

/* hdl/mia_pulse_gen.v */
// One-cycle pulse generator: a rising edge on a level, gated by an enable.
// Assumes level_i is already in the clock_i domain.
`timescale 1ns/100ps
`default_nettype none

module mia_pulse_gen #(
   parameter         W         = 8,
   parameter [W-1:0] PREV_INIT = {W{1'b0}}
) (
   input  wire         clock_i,
   input  wire         rst_n_i,
   input  wire [W-1:0] level_i,
   input  wire [W-1:0] enable_i,
   output reg  [W-1:0] pulse_o
);

   reg [W-1:0] prev_q;

   // ****************************************************************
   // Edge detect, one flop of history per channel
   // ****************************************************************
   // A held level never repeats the pulse; channels are independent
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prev_q  <= PREV_INIT;
         pulse_o <= {W{1'b0}};
      end else begin
         prev_q  <= level_i;
         pulse_o <= level_i & ~prev_q & enable_i;
      end
   end

endmodule

`default_nettype wire

/* hdl/mia_top.v */
// MAC subsystem interrupt aggregator: vector word, user-access done, pulses, core events.
// Assumes all event inputs come from logic on clock_i; registers reached by a plain port.
//
// Functional notes
// - User-access done interrupt when in-progress falls and its enable is set.
// - Raw register records each user-access completion regardless of mask.
// - Masked bit sets on enabled completion; writing one clears it.
// - Every vector source except user-access done is a level held while its cause stays active; user-access done holds until cleared.
// - Re-enabling the gate with a source active gives a fresh rising edge.
// - Levels combine into processor outputs; cause readable from vector register.
// - Vector: 31:28 zero, stats, host, link, user, tx, threshold, rx.
// - Combined interrupts reach the processor as system events 5 to 8.
// - Eight transmit pulses, enabled by set register, disabled by clear register.
// - One transmit pulse per finished DMA transfer, no acknowledgement.
// - Eight receive pulses, enabled by set register, disabled by clear register.
// - One receive pulse per finished receive DMA transfer, no acknowledgement.
// - Twelve event outputs, nine of them used at system level.
// - Per-core misc, rx, tx, threshold events; first three also to shared combiner.
// - Statistics level asserts while enabled and any counter MSB is set.
// - Threshold level asserts while enabled and free count at or below threshold.
`timescale 1ns/100ps
`default_nettype none
`include "mia_defines.vh"

module mia_top (
   input  wire                                   clock_i,
   input  wire                                   arst_n_i,
   // Register port
   input  wire [`MIA_ADDR_W-1:0]                 reg_addr_i,
   input  wire [31:0]                            reg_wdata_i,
   input  wire                                   reg_wr_i,
   input  wire                                   reg_rd_i,
   output reg  [31:0]                            reg_rdata_o,
   // Management unit
   input  wire [1:0]                             mgmt_user_access_reg_i,
   input  wire                                   phy_link_change_pending_i,
   // MAC level sources
   input  wire                                   stats_overflow_level_i,
   input  wire                                   descriptor_error_pending_i,
   input  wire [`MIA_CHANS-1:0]                  tx_completion_pending_i,
   input  wire [`MIA_CHANS-1:0]                  rx_completion_pending_i,
   input  wire [`MIA_CHANS*`MIA_CNT_W-1:0]       rx_free_count_i,
   input  wire [`MIA_CHANS*`MIA_CNT_W-1:0]       rx_flow_thresh_i,
   // DMA completion strobes
   input  wire [`MIA_CHANS-1:0]                  tx_dma_done_i,
   input  wire [`MIA_CHANS-1:0]                  rx_dma_done_i,
   // Pulse interrupts
   output wire [`MIA_CHANS-1:0]                  tx_pulse_o,
   output wire [`MIA_CHANS-1:0]                  rx_pulse_o,
   // Per-core events
   output reg  [`MIA_CORES-1:0]                  core_misc_event_o,
   output reg  [`MIA_CORES-1:0]                  core_rx_event_o,
   output reg  [`MIA_CORES-1:0]                  core_tx_event_o,
   output reg  [`MIA_CORES-1:0]                  core_rx_low_event_o,
   // Shared combiner: misc, rx, tx
   output reg  [2:0]                             shared_event_combiner_o,
   output wire                                   user_access_done_irq_o,
   output wire                                   irq_o
);

   // ****************************************************************
   // Reset synchroniser
   // ****************************************************************
   reg rst_meta_q;
   reg rst_n_q;

   always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // ****************************************************************
   // Functions
   // ****************************************************************
   function hit;
      input [`MIA_ADDR_W-1:0] addr;
      input [`MIA_ADDR_W-1:0] ofs;
      begin
         hit = (addr == ofs);
      end
   endfunction

   // Set-wins update for enable registers driven by set and clear ports
   function [31:0] set_clr;
      input [31:0] cur;
      input        set_wr;
      input        clr_wr;
      input [31:0] data;
      begin
         set_clr = cur;
         if (clr_wr) begin
            set_clr = set_clr & ~data;
         end
         if (set_wr) begin
            set_clr = set_clr | data;
         end
      end
   endfunction

   // ****************************************************************
   // Register state
   // ****************************************************************
   reg  [1:0]               user_raw_q;
   reg  [1:0]               user_done_enable_q;
   reg  [`MIA_CHANS-1:0]    tx_en_q;
   reg  [2*`MIA_CHANS-1:0]  rx_en_q;
   reg  [1:0]               mac_en_q;
   reg  [`MIA_GATE_W-1:0]   ctrl_unit_irq_gate_q;
   reg  [`MIA_EVT_W-1:0]    evt_stat_q;
   reg  [`MIA_EVT_W-1:0]    evt_mask_q;
   reg                      host_prev_q;

   wire                     wr_user_masked = reg_wr_i & hit(reg_addr_i, `MIA_OFS_USER_MASKED);
   wire                     wr_user_set    = reg_wr_i & hit(reg_addr_i, `MIA_OFS_USER_EN_SET);
   wire                     wr_user_clr    = reg_wr_i & hit(reg_addr_i, `MIA_OFS_USER_EN_CLR);
   wire                     wr_tx_set      = reg_wr_i & hit(reg_addr_i, `MIA_OFS_TX_EN_SET);
   wire                     wr_tx_clr      = reg_wr_i & hit(reg_addr_i, `MIA_OFS_TX_EN_CLR);
   wire                     wr_rx_set      = reg_wr_i & hit(reg_addr_i, `MIA_OFS_RX_EN_SET);
   wire                     wr_rx_clr      = reg_wr_i & hit(reg_addr_i, `MIA_OFS_RX_EN_CLR);
   wire                     wr_mac_set     = reg_wr_i & hit(reg_addr_i, `MIA_OFS_MAC_EN_SET);
   wire                     wr_mac_clr     = reg_wr_i & hit(reg_addr_i, `MIA_OFS_MAC_EN_CLR);
   wire                     wr_gate        = reg_wr_i & hit(reg_addr_i, `MIA_OFS_GATE);
   wire                     wr_evt_stat    = reg_wr_i & hit(reg_addr_i, `MIA_OFS_EVT_STAT);
   wire                     wr_evt_mask    = reg_wr_i & hit(reg_addr_i, `MIA_OFS_EVT_MASK);

   // ****************************************************************
   // Completion pulses
   // ****************************************************************
   wire [1:0]               user_done;

   // Falling in-progress flag is the completion; history starts at idle-high
   // so that a flag low out of reset is not taken as a completion
   mia_pulse_gen #(
      .W         (2),
      .PREV_INIT (2'b11)
   ) u_user_done (
      .clock_i  (clock_i),
      .rst_n_i  (rst_n_q),
      .level_i  (~mgmt_user_access_reg_i),
      .enable_i (2'b11),
      .pulse_o  (user_done)
   );

   mia_pulse_gen #(
      .W (`MIA_CHANS)
   ) u_tx_pulse (
      .clock_i  (clock_i),
      .rst_n_i  (rst_n_q),
      .level_i  (tx_dma_done_i),
      .enable_i (tx_en_q),
      .pulse_o  (tx_pulse_o)
   );

   mia_pulse_gen #(
      .W (`MIA_CHANS)
   ) u_rx_pulse (
      .clock_i  (clock_i),
      .rst_n_i  (rst_n_q),
      .level_i  (rx_dma_done_i),
      .enable_i (rx_en_q[`MIA_CHANS-1:0]),
      .pulse_o  (rx_pulse_o)
   );

   // ****************************************************************
   // Level sources
   // ****************************************************************
   reg  [`MIA_CHANS-1:0]    thr_below;
   integer                  ch;

   always @* begin
      thr_below = {`MIA_CHANS{1'b0}};
      for (ch = 0; ch < `MIA_CHANS; ch = ch + 1) begin
         thr_below[ch] = rx_free_count_i[ch*`MIA_CNT_W +: `MIA_CNT_W]
                         <= rx_flow_thresh_i[ch*`MIA_CNT_W +: `MIA_CNT_W];
      end
   end

   wire [`MIA_CHANS-1:0]    rx_low_buffer_pending  = thr_below
                                                   & rx_en_q[`MIA_RX_THR_EN_LSB +: `MIA_CHANS];
   wire                     stats_overflow_pending = stats_overflow_level_i
                                                   & mac_en_q[`MIA_MAC_EN_STAT];
   wire                     host_pending           = descriptor_error_pending_i
                                                   & mac_en_q[`MIA_MAC_EN_HOST];
   wire [1:0]               user_masked            = user_raw_q & user_done_enable_q;
   wire                     user_access_done_pending = |user_masked;

   // Level held for as long as the masked bit stands
   assign user_access_done_irq_o = user_access_done_pending;

   wire [31:0]              vector = {4'h0,
                                      stats_overflow_pending,
                                      host_pending,
                                      phy_link_change_pending_i,
                                      user_access_done_pending,
                                      tx_completion_pending_i,
                                      rx_low_buffer_pending,
                                      rx_completion_pending_i};

   // ****************************************************************
   // Register writes
   // ****************************************************************
   wire [31:0]              tx_en_d   = set_clr({24'h0, tx_en_q}, wr_tx_set, wr_tx_clr, reg_wdata_i);
   wire [31:0]              rx_en_d   = set_clr({16'h0, rx_en_q}, wr_rx_set, wr_rx_clr, reg_wdata_i);
   wire [31:0]              mac_en_d  = set_clr({30'h0, mac_en_q}, wr_mac_set, wr_mac_clr, reg_wdata_i);
   wire [31:0]              user_en_d = set_clr({30'h0, user_done_enable_q}, wr_user_set, wr_user_clr,
                                                reg_wdata_i);
   wire                     host_rise = descriptor_error_pending_i & ~host_prev_q;
   wire [`MIA_EVT_W-1:0]    evt_set   = {host_rise, user_done, rx_dma_done_i, tx_dma_done_i};

   always @(posedge clock_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         user_raw_q           <= 2'b00;
         user_done_enable_q   <= 2'b00;
         tx_en_q              <= {`MIA_CHANS{1'b0}};
         rx_en_q              <= {2*`MIA_CHANS{1'b0}};
         mac_en_q             <= 2'b00;
         ctrl_unit_irq_gate_q <= `MIA_GATE_RST;
         evt_stat_q           <= {`MIA_EVT_W{1'b0}};
         evt_mask_q           <= {`MIA_EVT_W{1'b0}};
         host_prev_q          <= 1'b0;
      end else begin
         // Raw capture ignores the mask; clearing the masked bit also clears raw,
         // a fresh completion in the same cycle wins over the clear
         user_raw_q <= (user_raw_q & ~(wr_user_masked ? reg_wdata_i[1:0] : 2'b00))
                       | user_done;
         user_done_enable_q <= user_en_d[1:0];
         tx_en_q            <= tx_en_d[`MIA_CHANS-1:0];
         rx_en_q            <= rx_en_d[2*`MIA_CHANS-1:0];
         mac_en_q           <= mac_en_d[1:0];
         if (wr_gate) begin
            ctrl_unit_irq_gate_q <= reg_wdata_i[`MIA_GATE_W-1:0];
         end
         evt_stat_q <= (evt_stat_q & ~(wr_evt_stat ? reg_wdata_i[`MIA_EVT_W-1:0] : {`MIA_EVT_W{1'b0}}))
                       | evt_set;
         if (wr_evt_mask) begin
            evt_mask_q <= reg_wdata_i[`MIA_EVT_W-1:0];
         end
         host_prev_q <= descriptor_error_pending_i;
      end
   end

   assign irq_o = |(evt_stat_q & evt_mask_q);

   // ****************************************************************
   // Per-core event outputs
   // ****************************************************************
   // Gate bits per core c: [4c] misc, [4c+1] rx, [4c+2] tx, [4c+3] threshold.
   // Core 0 carries system events 5..8 in the order misc, rx, tx, threshold.
   // Registered AND with the gate: clearing then setting a gate bit while the
   // source stays high gives the processor a new rising edge.
   wire                     misc_level = stats_overflow_pending | host_pending
                                       | phy_link_change_pending_i | user_access_done_pending;
   wire                     rx_level   = |rx_completion_pending_i;
   wire                     tx_level   = |tx_completion_pending_i;
   wire                     thr_level  = |rx_low_buffer_pending;
   integer                  c;

   always @(posedge clock_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         core_misc_event_o       <= {`MIA_CORES{1'b0}};
         core_rx_event_o         <= {`MIA_CORES{1'b0}};
         core_tx_event_o         <= {`MIA_CORES{1'b0}};
         core_rx_low_event_o     <= {`MIA_CORES{1'b0}};
         shared_event_combiner_o <= 3'b000;
      end else begin
         for (c = 0; c < `MIA_CORES; c = c + 1) begin
            core_misc_event_o[c]   <= misc_level & ctrl_unit_irq_gate_q[4*c];
            core_rx_event_o[c]     <= rx_level   & ctrl_unit_irq_gate_q[4*c+1];
            core_tx_event_o[c]     <= tx_level   & ctrl_unit_irq_gate_q[4*c+2];
            core_rx_low_event_o[c] <= thr_level  & ctrl_unit_irq_gate_q[4*c+3];
         end
         // Threshold events stay per core only; the other nine reach the combiner
         shared_event_combiner_o <= {
            |({misc_level, misc_level, misc_level} & {ctrl_unit_irq_gate_q[8],
                                                      ctrl_unit_irq_gate_q[4],
                                                      ctrl_unit_irq_gate_q[0]}),
            |({rx_level, rx_level, rx_level} & {ctrl_unit_irq_gate_q[9],
                                                ctrl_unit_irq_gate_q[5],
                                                ctrl_unit_irq_gate_q[1]}),
            |({tx_level, tx_level, tx_level} & {ctrl_unit_irq_gate_q[10],
                                                ctrl_unit_irq_gate_q[6],
                                                ctrl_unit_irq_gate_q[2]})};
      end
   end

   // ****************************************************************
   // Register reads
   // ****************************************************************
   reg [31:0] rdata_d;

   always @* begin
      case (reg_addr_i)
         `MIA_OFS_VECTOR:      rdata_d = vector;
         `MIA_OFS_USER_RAW:    rdata_d = {30'h0, user_raw_q};
         `MIA_OFS_USER_MASKED: rdata_d = {30'h0, user_masked};
         `MIA_OFS_USER_EN_SET: rdata_d = {30'h0, user_done_enable_q};
         `MIA_OFS_USER_EN_CLR: rdata_d = {30'h0, user_done_enable_q};
         `MIA_OFS_TX_EN_SET:   rdata_d = {24'h0, tx_en_q};
         `MIA_OFS_TX_EN_CLR:   rdata_d = {24'h0, tx_en_q};
         `MIA_OFS_RX_EN_SET:   rdata_d = {16'h0, rx_en_q};
         `MIA_OFS_RX_EN_CLR:   rdata_d = {16'h0, rx_en_q};
         `MIA_OFS_MAC_EN_SET:  rdata_d = {30'h0, mac_en_q};
         `MIA_OFS_MAC_EN_CLR:  rdata_d = {30'h0, mac_en_q};
         `MIA_OFS_GATE:        rdata_d = {20'h0, ctrl_unit_irq_gate_q};
         `MIA_OFS_EVT_STAT:    rdata_d = {13'h0, evt_stat_q};
         `MIA_OFS_EVT_MASK:    rdata_d = {13'h0, evt_mask_q};
         default:              rdata_d = `MIA_ZERO32;
      endcase
   end

   // Read data stand only in the cycle after the strobe
   always @(posedge clock_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         reg_rdata_o <= `MIA_ZERO32;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rdata_d;
      end else begin
         reg_rdata_o <= `MIA_ZERO32;
      end
   end

endmodule

`default_nettype wire

/* tb/mia_top_props.sv */
// Port-level assertions for the MAC interrupt aggregator.
// Assumes a bind onto mia_top; one clock, reset active low.
`timescale 1ns/100ps
`default_nettype none
module mia_top_props (
   input wire logic        clock_i,
   input wire logic        arst_n_i,
   input wire logic [7:0]  reg_addr_i,
   input wire logic        reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic        phy_link_change_pending_i,
   input wire logic [7:0]  tx_completion_pending_i,
   input wire logic [7:0]  rx_completion_pending_i,
   input wire logic [7:0]  tx_dma_done_i,
   input wire logic [7:0]  rx_dma_done_i,
   input wire logic [7:0]  tx_pulse_o,
   input wire logic [7:0]  rx_pulse_o,
   input wire logic [2:0]  core_misc_event_o,
   input wire logic [2:0]  core_rx_event_o,
   input wire logic [2:0]  core_tx_event_o,
   input wire logic [2:0]  shared_event_combiner_o,
   input wire logic        user_access_done_irq_o,
   input wire logic        irq_o
);
   // ****
   // Properties
   // ****
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);
   property p_tx_width;
      (tx_pulse_o & $past(tx_pulse_o)) == 8'h00;
   endproperty
   a_tx_width: assert property (p_tx_width) else $error("tx pulse longer than one cycle");
   property p_rx_width;
      (rx_pulse_o & $past(rx_pulse_o)) == 8'h00;
   endproperty
   a_rx_width: assert property (p_rx_width) else $error("rx pulse longer than one cycle");
   // A pulse needs a fresh rise of done one edge earlier; held done never repeats
   property p_tx_cause;
      (tx_pulse_o & ~($past(tx_dma_done_i) & ~$past(tx_dma_done_i, 2))) == 8'h00;
   endproperty
   a_tx_cause: assert property (p_tx_cause) else $error("tx pulse without done rise");
   property p_rx_cause;
      (rx_pulse_o & ~($past(rx_dma_done_i) & ~$past(rx_dma_done_i, 2))) == 8'h00;
   endproperty
   a_rx_cause: assert property (p_rx_cause) else $error("rx pulse without done rise");
   property p_vec_rsvd;
      reg_rd_i && reg_addr_i == 8'h00 |=> reg_rdata_o[31:28] == 4'h0;
   endproperty
   a_vec_rsvd: assert property (p_vec_rsvd) else $error("vector reserved bits set");
   property p_vec_fields;
      reg_rd_i && reg_addr_i == 8'h00 |=> reg_rdata_o[7:0] == $past(rx_completion_pending_i)
         && reg_rdata_o[23:16] == $past(tx_completion_pending_i)
         && reg_rdata_o[25] == $past(phy_link_change_pending_i);
   endproperty
   a_vec_fields: assert property (p_vec_fields) else $error("vector field mismatch");
   property p_shared;
      shared_event_combiner_o == {|core_misc_event_o, |core_rx_event_o, |core_tx_event_o};
   endproperty
   a_shared: assert property (p_shared) else $error("shared events differ from cores");
   property p_rdata_idle;
      !$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
   c_tx: cover property (|tx_pulse_o);
   c_user: cover property ($rose(user_access_done_irq_o));
   c_irq: cover property ($rose(irq_o));
endmodule
`default_nettype wire

/* tb/mia_intc_model.sv */
// Edge-triggered processor interrupt controller seen from the aggregator.
// Assumes pulses and events are synchronous to clock_i.
`timescale 1ns/100ps
`default_nettype none
module mia_intc_model (
   input  wire logic       clock_i,
   input  wire logic       rst_n_i,
   input  wire logic [7:0] tx_pulse_i,
   input  wire logic [7:0] rx_pulse_i,
   input  wire logic       misc_i,
   output var  logic [7:0] tx_seen_o,
   output var  logic [7:0] rx_seen_o,
   output var  logic [7:0] tx_bits_o,
   output var  logic [7:0] rx_bits_o,
   output var  logic [7:0] edges_o
);
   logic misc_q;
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {misc_q, tx_seen_o, rx_seen_o, tx_bits_o, rx_bits_o, edges_o} <= '0;
      end else begin
         misc_q <= misc_i;
         // The core only reacts to rising edges, so a level must drop first
         if (misc_i && !misc_q)
            edges_o <= edges_o + 8'h01;
         tx_seen_o <= tx_seen_o | tx_pulse_i;
         rx_seen_o <= rx_seen_o | rx_pulse_i;
         tx_bits_o <= tx_bits_o + 8'($countones(tx_pulse_i));
         rx_bits_o <= rx_bits_o + 8'($countones(rx_pulse_i));
      end
   end
endmodule
`default_nettype wire

/* tb/mac_interrupt_aggregator_bench.sv */
// Register-level bench for the aggregator with an interrupt controller model.
// Assumes mia_top, mia_intc_model and mia_top_props are compiled first.
`timescale 1ns/100ps
`default_nettype none
module mac_interrupt_aggregator_bench;
   logic         clock_i = 1'b0, arst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   logic [7:0]   reg_addr_i = 8'h00, txp = 8'h00, rxp = 8'h00, txd = 8'h00, rxd = 8'h00;
   logic [31:0]  reg_wdata_i = 32'h0, reg_rdata_o;
   logic [1:0]   busy = 2'b00;
   logic         link = 1'b0, stats = 1'b0, host = 1'b0, uirq, irq;
   logic [127:0] free = '0, thr = '0;
   logic [7:0]   txo, rxo, tx_seen, rx_seen, tx_bits, rx_bits, edges;
   logic [2:0]   misc, rxe, txe, lowe, shared;
   int           miscompares = 0, comparisons = 0;
   // ****
   // Design, partner and clock
   // ****
   mia_top uut (.clock_i(clock_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .mgmt_user_access_reg_i(busy),
      .phy_link_change_pending_i(link), .stats_overflow_level_i(stats), .descriptor_error_pending_i(host),
      .tx_completion_pending_i(txp), .rx_completion_pending_i(rxp), .rx_free_count_i(free),
      .rx_flow_thresh_i(thr), .tx_dma_done_i(txd), .rx_dma_done_i(rxd), .tx_pulse_o(txo), .rx_pulse_o(rxo),
      .core_misc_event_o(misc), .core_rx_event_o(rxe), .core_tx_event_o(txe), .core_rx_low_event_o(lowe),
      .shared_event_combiner_o(shared), .user_access_done_irq_o(uirq), .irq_o(irq));
   mia_intc_model partner (.clock_i(clock_i), .rst_n_i(arst_n_i), .tx_pulse_i(txo), .rx_pulse_i(rxo),
      .misc_i(misc[0]), .tx_seen_o(tx_seen), .rx_seen_o(rx_seen), .tx_bits_o(tx_bits), .rx_bits_o(rx_bits),
      .edges_o(edges));
   initial forever #12.5 clock_i = ~clock_i;
   // ****
   // Tasks
   // ****
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge clock_i);
      reg_wr_i    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge clock_i);
      reg_rd_i   <= 1'b0;
      #1 check($sformatf("reg %h", a), reg_rdata_o, exp);
   endtask
   task automatic final_report;
      if (miscompares == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ****
   // Tests
   // ****
   initial begin
      repeat (6) @(posedge clock_i);
      arst_n_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      // All registers and the unmapped slots at 0x38 and 0x3C read zero after reset
      for (int a = 0; a <= 60; a += 4)
         rd(8'(a), 32'h0);
      @(posedge clock_i);
      {rxp, txp, link, stats, host} <= {8'hA5, 8'h3C, 3'b111};
      free <= {8{16'h0001}};
      thr  <= {80'h0, 16'h0001, 32'h0};
      wr(8'h00, 32'hFFFF_FFFF);
      rd(8'h00, 32'h023C_00A5);
      wr(8'h24, 32'h3);
      wr(8'h1C, 32'h0400);
      rd(8'h00, 32'h0E3C_04A5);
      wr(8'h14, 32'h81);
      wr(8'h1C, 32'h02);
      @(posedge clock_i);
      {txd, rxd} <= {8'hFF, 8'h03};
      @(posedge clock_i);
      rxd <= 8'h00;
      @(posedge clock_i);
      rxd <= 8'h03;
      @(posedge clock_i);
      {txd, rxd} <= 16'h0;
      wr(8'h18, 32'h01);
      rd(8'h14, 32'h80);
      rd(8'h1C, 32'h0402);
      wr(8'h20, 32'h02);
      rd(8'h1C, 32'h0400);
      @(posedge clock_i);
      txd <= 8'hFF;
      @(posedge clock_i);
      txd <= 8'h00;
      repeat (3) @(posedge clock_i);
      check("tx seen", 32'(tx_seen), 32'h81);
      check("tx count", 32'(tx_bits), 32'h3);
      check("rx seen", 32'(rx_seen), 32'h02);
      check("rx count", 32'(rx_bits), 32'h2);
      wr(8'h2C, 32'h001);
      wr(8'h2C, 32'h000);
      wr(8'h2C, 32'h00F);
      repeat (2) @(posedge clock_i);
      #1 check("misc", 32'(misc), 32'h1);
      check("low", 32'(lowe), 32'h1);
      check("shared", 32'(shared), 32'h7);
      check("rx tx evt", 32'({rxe, txe}), 32'h09);
      check("edges", 32'(edges), 32'h2);
      wr(8'h30, 32'hFFFF_FFFF);
      wr(8'h0C, 32'h1);
      @(posedge clock_i);
      busy <= 2'b11;
      @(posedge clock_i);
      busy <= 2'b00;
      repeat (3) @(posedge clock_i);
      #1 check("user irq", 32'(uirq), 32'h1);
      rd(8'h04, 32'h3);
      rd(8'h08, 32'h1);
      rd(8'h00, 32'h0F3C_04A5);
      rd(8'h30, 32'h0003_0000);
      check("irq masked", 32'(irq), 32'h0);
      wr(8'h34, 32'h0001_0000);
      #1 check("irq", 32'(irq), 32'h1);
      wr(8'h08, 32'h1);
      rd(8'h08, 32'h0);
      rd(8'h04, 32'h2);
      check("user irq clr", 32'(uirq), 32'h0);
      wr(8'h30, 32'h0001_0000);
      #1 check("irq clr", 32'(irq), 32'h0);
      final_report;
   end
   initial begin
      repeat (3000) @(posedge clock_i);
      miscompares++;
      final_report;
   end
endmodule
bind mia_top mia_top_props chk (.clock_i(clock_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .phy_link_change_pending_i(phy_link_change_pending_i),
   .tx_completion_pending_i(tx_completion_pending_i), .rx_completion_pending_i(rx_completion_pending_i),
   .tx_dma_done_i(tx_dma_done_i), .rx_dma_done_i(rx_dma_done_i), .tx_pulse_o(tx_pulse_o),
   .rx_pulse_o(rx_pulse_o), .core_misc_event_o(core_misc_event_o), .core_rx_event_o(core_rx_event_o),
   .core_tx_event_o(core_tx_event_o), .shared_event_combiner_o(shared_event_combiner_o),
   .user_access_done_irq_o(user_access_done_irq_o), .irq_o(irq_o));
`default_nettype wire
